// ==== dv/test_sbi_exec.sv ====
// Purpose: Self-checking bench for the skip/branch/increment executor
// Assumes: File bank starts at FILE_RST, nothing else writes it
// Notes:   Second word is offered in the flush cycle to prove the discard
`default_nettype none
module test_sbi_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import sbi_pkg::*;
  logic              clk_i;
  logic              reset_i;
  logic              instr_valid_i;
  logic [INSTR_W-1:0] instr_i;
  logic [LATCH_W-1:0] pc_latch_i;
  logic [PC_W-1:0]   pc_o;
  logic [DATA_W-1:0] working_o;
  logic              zero_o;
  logic              busy_o;
  logic              retire_o;
  logic              bz;
  logic              rt;
  logic [PC_W-1:0]   pv;
  int                error_cnt;
  int                n_checks;
  localparam logic [13:0] NOP = 14'h0000;

  sbi_exec u_sbi_exec (.clk_i(clk_i), .reset_i(reset_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .pc_latch_i(pc_latch_i), .pc_o(pc_o), .working_o(working_o),
    .zero_o(zero_o), .busy_o(busy_o), .retire_o(retire_o));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Busy and pc are sampled just after the first word lands
  task automatic run(input logic [13:0] a, b);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i       <= a;
    @(posedge clk_i);
    instr_i <= b;
    #1;
    bz = busy_o;
    pv = pc_o;
    rt = retire_o;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask : run

  // Reset state seen at the first edge after release
  task automatic t_rst();
    @(posedge clk_i);
    #1;
    chk("pc", 16'(pc_o), 16'h0000);
    chk("w", 16'(working_o), 16'h0000);
    chk("z", 16'(zero_o), 16'h0000);
    chk("busy", 16'(busy_o), 16'h0000);
    chk("ret", 16'(retire_o), 16'h0000);
    $display("test reset done");
  endtask : t_rst

  task automatic t_or();
    run({OP_ORLIT, 8'h00}, NOP);
    chk("ret", 16'(rt), 16'h0001);
    chk("w", 16'(working_o), 16'h0000);
    chk("z", 16'(zero_o), 16'h0001);
    run({OP_ORLIT, 8'hA5}, NOP);
    chk("w", 16'(working_o), 16'h00A5);
    chk("z", 16'(zero_o), 16'h0000);
    $display("test or_literal done");
  endtask : t_or

  task automatic t_inc();
    run({OP_INC_FILE, 1'b1, 7'h03}, NOP);
    chk("w", 16'(working_o), 16'h00A5);
    run({OP_INC_FILE, 1'b0, 7'h03}, NOP);
    chk("w", 16'(working_o), 16'h0002);
    chk("z", 16'(zero_o), 16'h0000);
    $display("test increment done");
  endtask : t_inc

  task automatic t_dsk();
    run({OP_DECFZ, 1'b1, 7'h03}, {OP_ORLIT, 8'hFF});
    chk("busy", 16'(bz), 16'h0001);
    chk("ret", 16'(rt), 16'h0000);
    chk("w", 16'(working_o), 16'h0002);
    run({OP_DECFZ, 1'b0, 7'h03}, NOP);
    chk("busy", 16'(bz), 16'h0000);
    chk("ret", 16'(rt), 16'h0001);
    chk("w", 16'(working_o), 16'h00FF);
    chk("z", 16'(zero_o), 16'h0000);
    $display("test decrement_skip done");
  endtask : t_dsk

  task automatic t_isk();
    run({OP_DECFZ, 1'b1, 7'h05}, NOP);
    run({OP_DECFZ, 1'b1, 7'h06}, NOP);
    run({OP_INC_FILE, 1'b0, 7'h06}, NOP);
    chk("z", 16'(zero_o), 16'h0001);
    run({OP_INCFZ, 1'b1, 7'h05}, {OP_ORLIT, 8'h3C});
    chk("busy", 16'(bz), 16'h0001);
    chk("w", 16'(working_o), 16'h0000);
    chk("z", 16'(zero_o), 16'h0001);
    $display("test increment_skip done");
  endtask : t_isk

  task automatic t_br();
    @(posedge clk_i);
    pc_latch_i <= 8'h18;
    run({OP_BRANCH, 11'h7FF}, {OP_ORLIT, 8'h01});
    chk("pc", 16'(pv), 16'h1FFF);
    chk("busy", 16'(bz), 16'h0001);
    chk("ret", 16'(rt), 16'h0000);
    chk("z", 16'(zero_o), 16'h0001);
    @(posedge clk_i);
    pc_latch_i <= 8'hE7;
    run({OP_BRANCH, 11'h2AA}, NOP);
    chk("pc", 16'(pv), 16'h02AA);
    $display("test branch done");
  endtask : t_br

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    error_cnt     = 0;
    n_checks      = 0;
    reset_i       = 1'b1;
    instr_valid_i = 1'b0;
    instr_i       = NOP;
    pc_latch_i    = 8'h00;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    t_rst();
    t_or();
    t_inc();
    t_dsk();
    t_isk();
    t_br();
    wrap_up();
  end
endmodule : test_sbi_exec
`default_nettype wire

// ==== src/sbi_exec.sv ====
// Purpose: Executes five instructions of a small 8-bit core
// Assumes: One instruction offered per cycle on instr_valid_i
// Notes:   Skips and branches spend one flush cycle as a no-operation
`default_nettype none
module sbi_exec
  import sbi_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       reset_i,
  input  wire logic                       instr_valid_i,
  input  wire logic [sbi_pkg::INSTR_W-1:0] instr_i,
  input  wire logic [sbi_pkg::LATCH_W-1:0] pc_latch_i,
  output logic      [sbi_pkg::PC_W-1:0]    pc_o,
  output logic      [sbi_pkg::DATA_W-1:0]  working_o,
  output logic                             zero_o,
  output logic                             busy_o,
  output logic                             retire_o
);
  import sbi_pkg::*;

  logic [DATA_W-1:0]  file_r [2**FADDR_W];
  logic [DATA_W-1:0]  w_r;
  logic               z_r;
  logic [PC_W-1:0]    pc_r;
  sbi_state_type      state_r;
  logic               retire_r;
  logic               busy_r;

  logic [5:0]         op6;
  logic [FADDR_W-1:0] faddr;
  logic               dest;
  logic [DATA_W-1:0]  fval;
  logic [DATA_W-1:0]  res_nxt;
  logic               is_dec, is_incz, is_inc, is_or, is_br, go;
  logic               wr_file, wr_w, upd_z, skip;

  assign op6     = instr_i[INSTR_W-1 -: 6];
  assign faddr   = instr_i[FADDR_W-1:0];
  assign dest    = instr_i[DEST_BIT];
  assign fval    = file_r[faddr];
  assign go      = instr_valid_i && (state_r == SBI_EXEC);
  assign is_dec  = go && (op6 == OP_DECFZ);
  assign is_incz = go && (op6 == OP_INCFZ);
  assign is_inc  = go && (op6 == OP_INC_FILE);
  assign is_or   = go && (op6 == OP_ORLIT);
  assign is_br   = go && (instr_i[INSTR_W-1 -: 3] == OP_BRANCH);

  always_comb begin
    res_nxt = fval;
    if (is_dec) begin
      res_nxt = fval - 8'h01;
    end else if (is_incz || is_inc) begin
      res_nxt = fval + 8'h01;
    end else if (is_or) begin
      res_nxt = w_r | instr_i[DATA_W-1:0];
    end
  end

  // Destination select for the file arithmetic group
  assign wr_file = (is_dec || is_incz || is_inc) && dest;
  assign wr_w    = ((is_dec || is_incz || is_inc) && !dest) || is_or;
  assign upd_z   = is_inc || is_or; // skips and branch keep flags
  assign skip    = (is_dec || is_incz) && (res_nxt == 8'h00);

  // File bank clears on reset so skip counts start from a known value
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 2**FADDR_W; i++) begin
        file_r[i] <= FILE_RST;
      end
    end else if (wr_file) begin
      file_r[faddr] <= res_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      w_r <= W_RST;
    end else if (wr_w) begin
      w_r <= res_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      z_r <= Z_RST;
    end else if (upd_z) begin
      z_r <= (res_nxt == 8'h00);
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pc_r <= PC_RST;
    end else if (is_br) begin
      pc_r <= {pc_latch_i[LATCH_HI:LATCH_LO],
               instr_i[LIT_BR_W-1:0]};
    end else if (go || state_r == SBI_FLUSH) begin
      pc_r <= pc_r + 13'h0001;
    end
  end

  // Flush state discards whatever is fetched next
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= SBI_EXEC;
    end else begin
      case (state_r)
        SBI_EXEC: begin
          if (skip || is_br) begin
            state_r <= SBI_FLUSH;
          end
        end
        SBI_FLUSH: state_r <= SBI_EXEC;
        default:   state_r <= SBI_EXEC;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      retire_r <= 1'b0;
    end else begin
      retire_r <= go && !skip && !is_br;
    end
  end

  // Busy mirrors the flush state from its own flop, no decode on the pin
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_r <= BUSY_RST;
    end else begin
      busy_r <= (state_r == SBI_EXEC) && (skip || is_br);
    end
  end

  assign pc_o      = pc_r;
  assign working_o = w_r;
  assign zero_o    = z_r;
  assign busy_o    = busy_r;
  assign retire_o  = retire_r;

  // Results are judged one edge on, once the write has landed
  dec_keeps_z_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    is_dec |=> $stable(z_r))
    else $error("z changed on dec skip");

  dec_dest_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (is_dec && !dest) |=> w_r == $past(fval) - 8'h01)
    else $error("dec result wrong");

  skip_flush_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    skip |=> busy_o ##1 !busy_o)
    else $error("skip not 2 cycles");

  dec_noskip_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (is_dec && res_nxt != 8'h00) |=> !busy_o && retire_o)
    else $error("dec skipped on non-zero");

  // The discarded word must leave no trace in W or Z
  flush_drop_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    busy_o |=> $stable(w_r) && $stable(z_r))
    else $error("flushed word executed");

  incz_skip_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (is_incz && fval == 8'hFF) |=> busy_o)
    else $error("inc skip");

  incz_keeps_z_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    is_incz |=> $stable(z_r))
    else $error("z changed on inc skip");

  inc_zero_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    is_inc |=> (z_r == ($past(fval) == 8'hFF)))
    else $error("inc z");

  dest_w_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (is_inc && !dest) |=> w_r == $past(fval) + 8'h01)
    else $error("dest w wrong");

  dest_file_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (is_inc && dest) |=> file_r[$past(faddr)] == $past(fval) + 8'h01)
    else $error("dest file wrong");

  br_target_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    is_br |=> pc_o == {$past(pc_latch_i[LATCH_HI:LATCH_LO]),
                       $past(instr_i[LIT_BR_W-1:0])})
    else $error("branch target wrong");

  br_flags_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    is_br |=> busy_o && $stable(z_r))
    else $error("branch timing");

  br_two_cyc_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    is_br |=> busy_o ##1 !busy_o)
    else $error("branch not 2 cycles");

  or_result_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    is_or |=> w_r == ($past(w_r) | $past(instr_i[DATA_W-1:0])))
    else $error("or result wrong");

  or_zero_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    is_or |=> z_r == (w_r == 8'h00))
    else $error("or z");

  nz_clear_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (upd_z && res_nxt != 8'h00) |=> !z_r)
    else $error("z kept");

  skip_seen_c: cover property (@(posedge clk_i) disable iff (reset_i) skip);
  branch_seen_c: cover property (@(posedge clk_i) disable iff (reset_i) is_br);
  or_zero_c: cover property (@(posedge clk_i) disable iff (reset_i)
    is_or && res_nxt == 8'h00);
  incz_skip_c: cover property (@(posedge clk_i) disable iff (reset_i)
    is_incz && skip);
  flush_drop_c: cover property (@(posedge clk_i) disable iff (reset_i)
    busy_o && instr_valid_i);
endmodule : sbi_exec
`default_nettype wire

// ==== src/sbi_pkg.sv ====
// Purpose: Shared constants for the skip/branch/increment executor
// Assumes: 14-bit instruction words, 128-entry file register bank
// Notes:   Opcode patterns match the upper instruction bits
`default_nettype none
package sbi_pkg;
  localparam int unsigned INSTR_W     = 14;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned FADDR_W     = 7;
  localparam int unsigned PC_W        = 13;
  localparam int unsigned LIT_BR_W    = 11;
  localparam int unsigned LATCH_W     = 8;
  // Opcode fields
  localparam logic [5:0] OP_DECFZ     = 6'h0B;
  localparam logic [5:0] OP_INCFZ     = 6'h0F;
  localparam logic [5:0] OP_INC_FILE  = 6'h0A;
  localparam logic [5:0] OP_ORLIT     = 6'h38;
  localparam logic [2:0] OP_BRANCH    = 3'h5;
  // Field positions
  localparam int unsigned DEST_BIT    = 7;
  localparam int unsigned LATCH_HI    = 4;
  localparam int unsigned LATCH_LO    = 3;
  // Reset values
  localparam logic [DATA_W-1:0] W_RST    = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
  localparam logic [DATA_W-1:0] FILE_RST = 8'h00;
  localparam logic              Z_RST    = 1'b0;
  localparam logic              BUSY_RST = 1'b0;
  typedef enum logic [1:0] {
    SBI_EXEC, SBI_FLUSH
  } sbi_state_type;
endpackage : sbi_pkg
`default_nettype wire
